// ### hdl/mode_reg_pkg.sv
package mode_reg_pkg;

    // ------------------------------------------------------------
    // Command and register select
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int BANK_W = 3;
    localparam logic [2:0] BANK_MR = 3'h0;
    localparam logic [2:0] BANK_EMR1 = 3'h1;
    localparam logic [2:0] BANK_EMR2 = 3'h2;
    localparam logic [2:0] BANK_EMR3 = 3'h3;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int MR_BL_LSB = 0;
    localparam int MR_BT_BIT = 3;
    localparam int MR_CL_LSB = 4;
    localparam int MR_TM_BIT = 7;
    localparam int MR_DLLRST_BIT = 8;
    localparam int MR_WR_LSB = 9;
    localparam logic [2:0] BL_CODE_4 = 3'h2;
    localparam logic [2:0] BL_CODE_8 = 3'h3;
    localparam logic [2:0] CL_MIN = 3'h3;
    localparam logic [2:0] CL_MAX = 3'h7;

    // ------------------------------------------------------------
    // Extended register 1 fields
    // ------------------------------------------------------------
    localparam int EMR1_DLL_BIT = 0;
    localparam int EMR1_AL_LSB = 3;
    localparam int EMR1_OCD_LSB = 7;
    localparam logic [2:0] AL_MAX = 3'h6;
    localparam logic [2:0] OCD_DEFAULT = 3'h7;
    localparam logic [2:0] OCD_EXIT = 3'h0;

    // ------------------------------------------------------------
    // Reset values and timing
    // ------------------------------------------------------------
    localparam logic [13:0] MODE_RESET = 14'h0000;
    localparam int DLL_LOCK_CYCLES = 200;
    localparam int CLK_PERIOD_NS = 10;
    localparam int MODE_SET_CYCLE_TIME_NS = 20;
    localparam int MODE_SET_CYCLES =
        (MODE_SET_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : mode_reg_pkg

// ### hdl/sync3.sv
`timescale 1ns/10ps
`default_nettype none
module sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_dout;

    always_comb begin
        next_dout = (s2 == s3) ? s3 : dout;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            dout <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            dout <= next_dout;
        end
    end

endmodule : sync3
`default_nettype wire

// ### hdl/ddr2_init_and_mode_register.sv
`timescale 1ns/10ps
`default_nettype none
module ddr2_init_and_mode_register (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] bank,
    input wire logic [13:0] addr,
    input wire logic termination_enable,
    // Bank state from the array logic
    input wire logic all_banks_idle,
    // Decoded mode settings
    output logic [13:0] operating_mode_register,
    output logic [2:0] burst_length,
    output logic burst_interleaved,
    output logic [2:0] cas_latency,
    output logic [2:0] additive_latency,
    output logic [3:0] read_latency,
    output logic [3:0] write_latency,
    output logic [2:0] write_recovery,
    output logic test_mode,
    output logic dll_enabled,
    output logic dll_locked,
    output logic mode_valid,
    output logic mode_error,
    output logic ready
);

    // ------------------------------------------------------------
    // Reset release and pin sampling
    // ------------------------------------------------------------
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_q1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n <= rst_q1;
        end
    end

    logic [23:0] pin_raw;
    logic [23:0] pin;

    assign pin_raw = {cke, cs_n, ras_n, cas_n, we_n, bank, addr, termination_enable,
        all_banks_idle};

    sync3 #(.W(24)) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .din(pin_raw),
        .dout(pin)
    );

    logic s_cke;
    logic s_cs_n;
    logic s_ras_n;
    logic s_cas_n;
    logic s_we_n;
    logic [2:0] s_bank;
    logic [13:0] s_addr;
    logic s_idle;

    assign s_cke = pin[23];
    assign s_cs_n = pin[22];
    assign s_ras_n = pin[21];
    assign s_cas_n = pin[20];
    assign s_we_n = pin[19];
    assign s_bank = pin[18:16];
    assign s_addr = pin[15:2];
    assign s_idle = pin[0];

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic load_cmd;
    logic wr_mr;
    logic wr_emr1;
    logic wr_emr2;
    logic wr_emr3;
    logic cmd_ok;
    logic [1:0] gap_cnt;

    always_comb begin
        load_cmd = s_cke && !s_cs_n && !s_ras_n && !s_cas_n && !s_we_n;
        cmd_ok = s_idle && (gap_cnt == 2'h0);
        wr_mr = load_cmd && cmd_ok && (s_bank == mode_reg_pkg::BANK_MR);
        wr_emr1 = load_cmd && cmd_ok && (s_bank == mode_reg_pkg::BANK_EMR1);
        wr_emr2 = load_cmd && cmd_ok && (s_bank == mode_reg_pkg::BANK_EMR2);
        wr_emr3 = load_cmd && cmd_ok && (s_bank == mode_reg_pkg::BANK_EMR3);
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [13:0] emr1;
    logic [7:0] lock_cnt;
    logic ocd_default_seen;
    logic [13:0] next_mr;
    logic [13:0] next_emr1;
    logic [1:0] next_gap_cnt;
    logic [7:0] next_lock_cnt;
    logic next_dll_locked;
    logic next_mode_valid;
    logic next_emr1_valid;
    logic emr1_valid;
    logic next_ocd_default_seen;
    logic next_ready;

    always_comb begin
        next_mr = operating_mode_register;
        next_emr1 = emr1;
        next_gap_cnt = (gap_cnt != 2'h0) ? gap_cnt - 2'h1 : 2'h0;
        next_lock_cnt = lock_cnt;
        next_dll_locked = dll_locked;
        next_mode_valid = mode_valid;
        next_emr1_valid = emr1_valid;
        next_ocd_default_seen = ocd_default_seen;
        next_ready = ready;
        // Countdown first, so a new DLL reset or disable in the same cycle wins
        if (lock_cnt != 8'h00) begin
            next_lock_cnt = lock_cnt - 8'h01;
            if (lock_cnt == 8'h01) begin
                next_dll_locked = 1'b1;
            end
        end
        if (load_cmd && cmd_ok) begin
            next_gap_cnt = 2'(mode_reg_pkg::MODE_SET_CYCLES);
        end
        if (wr_mr) begin
            next_mr = s_addr;
            next_mode_valid = 1'b1;
            if (s_addr[mode_reg_pkg::MR_DLLRST_BIT]) begin
                next_lock_cnt = 8'(mode_reg_pkg::DLL_LOCK_CYCLES);
                next_dll_locked = 1'b0;
            end
        end
        if (wr_emr1) begin
            next_emr1 = s_addr;
            next_emr1_valid = 1'b1;
            if (s_addr[mode_reg_pkg::EMR1_OCD_LSB +: 3] == mode_reg_pkg::OCD_DEFAULT) begin
                next_ocd_default_seen = 1'b1;
            end else if (s_addr[mode_reg_pkg::EMR1_OCD_LSB +: 3] == mode_reg_pkg::OCD_EXIT
                    && ocd_default_seen) begin
                next_ocd_default_seen = 1'b0;
                next_ready = 1'b1;
            end
            if (s_addr[mode_reg_pkg::EMR1_DLL_BIT]) begin
                next_dll_locked = 1'b0;
            end
        end
    end

    // Array contents are not touched by any of this logic
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operating_mode_register <= mode_reg_pkg::MODE_RESET;
            emr1 <= mode_reg_pkg::MODE_RESET;
            gap_cnt <= 2'h0;
            lock_cnt <= 8'h00;
            dll_locked <= 1'b0;
            mode_valid <= 1'b0;
            emr1_valid <= 1'b0;
            ocd_default_seen <= 1'b0;
            ready <= 1'b0;
        end else begin
            operating_mode_register <= next_mr;
            emr1 <= next_emr1;
            gap_cnt <= next_gap_cnt;
            lock_cnt <= next_lock_cnt;
            dll_locked <= next_dll_locked;
            mode_valid <= next_mode_valid;
            emr1_valid <= next_emr1_valid;
            ocd_default_seen <= next_ocd_default_seen;
            ready <= next_ready;
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [2:0] bl_code;
    logic [2:0] cl_code;
    logic [2:0] al_code;
    logic [3:0] next_rl;
    logic next_err;

    always_comb begin
        bl_code = operating_mode_register[mode_reg_pkg::MR_BL_LSB +: 3];
        cl_code = operating_mode_register[mode_reg_pkg::MR_CL_LSB +: 3];
        al_code = emr1[mode_reg_pkg::EMR1_AL_LSB +: 3];
        next_rl = {1'b0, cl_code} + {1'b0, al_code};
        next_err = 1'b0;
        if (mode_valid && bl_code != mode_reg_pkg::BL_CODE_4
                && bl_code != mode_reg_pkg::BL_CODE_8) begin
            next_err = 1'b1;
        end
        if (mode_valid && (cl_code < mode_reg_pkg::CL_MIN)) begin
            next_err = 1'b1;
        end
        if (emr1_valid && (al_code > mode_reg_pkg::AL_MAX)) begin
            next_err = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            burst_length <= 3'h0;
            burst_interleaved <= 1'b0;
            cas_latency <= 3'h0;
            additive_latency <= 3'h0;
            read_latency <= 4'h0;
            write_latency <= 4'h0;
            write_recovery <= 3'h0;
            test_mode <= 1'b0;
            dll_enabled <= 1'b0;
            mode_error <= 1'b0;
        end else begin
            burst_length <= bl_code;
            burst_interleaved <= operating_mode_register[mode_reg_pkg::MR_BT_BIT];
            cas_latency <= cl_code;
            additive_latency <= al_code;
            read_latency <= next_rl;
            write_latency <= next_rl - 4'h1;
            write_recovery <= operating_mode_register[mode_reg_pkg::MR_WR_LSB +: 3];
            test_mode <= operating_mode_register[mode_reg_pkg::MR_TM_BIT];
            dll_enabled <= emr1_valid && !emr1[mode_reg_pkg::EMR1_DLL_BIT];
            mode_error <= next_err;
        end
    end

endmodule : ddr2_init_and_mode_register
`default_nettype wire

// ### sim/ddr2_init_and_mode_register_properties.sv
`timescale 1ns/10ps
`default_nettype none
module mode_reg_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] bank,
    input wire logic [13:0] addr,
    // Decoded settings
    input wire logic [13:0] operating_mode_register,
    input wire logic [2:0] cas_latency,
    input wire logic [2:0] additive_latency,
    input wire logic [3:0] read_latency,
    input wire logic [3:0] write_latency,
    input wire logic dll_locked,
    input wire logic mode_valid,
    input wire logic mode_error,
    input wire logic ready
);
    logic mrs;
    logic [9:0] age;
    logic [9:0] dll_age;
    logic [9:0] next_age;
    logic [9:0] next_dll_age;

    // Saturating ages of the last mode write and of the last DLL reset or DLL disable on the pins
    always_comb begin
        mrs = cke && !cs_n && !ras_n && !cas_n && !we_n && bank == 3'h0;
        next_age = mrs ? 10'h000 : age + 10'(age != 10'h3ff);
        next_dll_age = ((mrs && addr[8]) || (cke && !cs_n && !ras_n && !cas_n && !we_n
            && bank == 3'h1 && addr[0])) ? 10'h000 : dll_age + 10'(dll_age != 10'h3ff);
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            age <= 10'h3ff;
            dll_age <= 10'h3ff;
        end else begin
            age <= next_age;
            dll_age <= next_dll_age;
        end
    end

    default clocking @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    a_load_from_pins: assert property (
        $changed(operating_mode_register) |-> age <= 10'h008) else $error("load without write");
    a_valid_on_load: assert property (
        $changed(operating_mode_register) |-> mode_valid) else $error("load not flagged");
    a_dll_wait: assert property (
        $rose(dll_locked) |-> dll_age >= 10'h0c8) else $error("lock too early");
    a_dll_drop: assert property (
        $fell(dll_locked) |-> dll_age <= 10'h008) else $error("lock lost without reset");
    a_ready_sticky: assert property (
        ready |=> ready) else $error("ready dropped");
    a_write_latency: assert property (
        (read_latency != 4'h0 && $stable(read_latency)) [*3] |->
        write_latency == read_latency - 4'h1) else $error("write latency wrong");
    a_read_latency: assert property (
        (mode_valid && $stable(cas_latency) && $stable(additive_latency)) [*3] |->
        read_latency == {1'b0, cas_latency} + {1'b0, additive_latency})
        else $error("read latency wrong");
    a_cl_error: assert property (
        (mode_valid && operating_mode_register[6:4] < 3'h3) [*3] |-> mode_error)
        else $error("low latency accepted");

    c_lock: cover property ($rose(dll_locked));
    c_ready: cover property ($rose(ready));
    c_error: cover property ($rose(mode_error));
endmodule : mode_reg_checker
`default_nettype wire

// ### sim/mem_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module mem_ctrl_model #(
    parameter int PWR_WAIT = 40,
    parameter int CKE_WAIT = 40
) (
    // Clock
    input wire logic clk,
    // Command pins
    output logic cke,
    output logic cs_n,
    output logic ras_n,
    output logic cas_n,
    output logic we_n,
    output logic [2:0] bank,
    output logic [13:0] addr,
    output logic termination_enable
);
    initial begin
        cke = 1'b0;
        termination_enable = 1'b0;
        cs_n = 1'b1;
        {ras_n, cas_n, we_n} = 3'h7;
        bank = 3'h0;
        addr = 14'h0000;
    end

    // Command held two edges, then deselected with inverted pins and spaced out
    task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a);
        @(posedge clk);
        cs_n <= 1'b0;
        {ras_n, cas_n, we_n} <= c;
        bank <= b;
        addr <= a;
        repeat (2) @(posedge clk);
        cs_n <= 1'b1;
        {ras_n, cas_n, we_n} <= ~c;
        bank <= ~b;
        addr <= ~a;
        repeat (6) @(posedge clk);
        #1;
    endtask : issue

    // Waits are fixed cycle counts set by PWR_WAIT and CKE_WAIT
    task automatic power_up(input logic [13:0] mr);
        repeat (PWR_WAIT) @(posedge clk);
        cke <= 1'b1;
        repeat (CKE_WAIT) @(posedge clk);
        issue(3'h2, 3'h0, 14'h0400);
        issue(3'h0, mode_reg_pkg::BANK_EMR2, 14'h0000);
        issue(3'h0, mode_reg_pkg::BANK_EMR3, 14'h0000);
        issue(3'h0, mode_reg_pkg::BANK_EMR1, 14'h0000);
        issue(3'h0, mode_reg_pkg::BANK_MR, mr | 14'h0100);
        issue(3'h2, 3'h0, 14'h0400);
        repeat (2) issue(3'h1, 3'h0, 14'h0000);
    endtask : power_up
endmodule : mem_ctrl_model
`default_nettype wire

// ### sim/tb_ddr2_init_and_mode_register.sv
`timescale 1ns/10ps
`default_nettype none
module tb_ddr2_init_and_mode_register;
    logic clk, arst_n, cke, cs_n, ras_n, cas_n, we_n, termination_enable, all_banks_idle;
    logic [2:0] bank, burst_length, cas_latency, additive_latency, write_recovery, al;
    logic [13:0] addr, operating_mode_register, v;
    logic burst_interleaved, test_mode, dll_enabled, dll_locked, mode_valid, mode_error, ready;
    logic [3:0] read_latency, write_latency;
    int err_total;
    int n_compared;

    ddr2_init_and_mode_register dut (.*);
    mem_ctrl_model ctl (.*);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic mrs(input logic [2:0] b, input logic [13:0] a);
        ctl.issue(3'h0, b, a);
    endtask : mrs

    task automatic final_report();
        if (err_total == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : final_report

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report();
    end

    initial begin
        err_total = 0;
        n_compared = 0;
        arst_n = 1'b0;
        all_banks_idle = 1'b1;
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        check({mode_valid, operating_mode_register}, 15'h0000);
        ctl.power_up(14'h0032);
        check({dll_locked, operating_mode_register}, 15'h0132);
        all_banks_idle <= 1'b0;
        mrs(3'h0, 14'h0043);
        all_banks_idle <= 1'b1;
        ctl.issue(3'h1, 3'h0, 14'h0043);
        for (int b = 2; b < 8; b++) begin
            mrs(3'(b), 14'h0043);
        end
        check(operating_mode_register, 14'h0132);
        for (int cl = 3; cl < 8; cl++) begin
            al = (cl == 7) ? 3'h6 : 3'(cl - 3);
            mrs(mode_reg_pkg::BANK_EMR1, {8'h00, al, 3'h0});
            for (int i = 0; i < 2; i++) begin
                v = {2'h0, 3'(cl - 1), 2'h0, 3'(cl), 1'(i),
                    i ? mode_reg_pkg::BL_CODE_8 : mode_reg_pkg::BL_CODE_4};
                mrs(mode_reg_pkg::BANK_MR, v);
                check(operating_mode_register, v);
                check({burst_interleaved, burst_length, cas_latency, write_recovery},
                    {v[3], v[2:0], v[6:4], v[11:9]});
                check({additive_latency, read_latency}, {al, 4'(cl) + {1'b0, al}});
                check(write_latency, 4'(cl) + {1'b0, al} - 4'h1);
                check({mode_error, test_mode, dll_enabled}, 3'h1);
            end
        end
        check(ready, 1'b0);
        mrs(mode_reg_pkg::BANK_MR, 14'h0031);
        check(mode_error, 1'b1);
        mrs(mode_reg_pkg::BANK_MR, 14'h00a2);
        check({mode_error, test_mode}, 2'h3);
        mrs(mode_reg_pkg::BANK_MR, 14'h0032);
        mrs(mode_reg_pkg::BANK_EMR1, 14'h0039);
        check({mode_error, dll_enabled}, 2'h2);
        mrs(mode_reg_pkg::BANK_MR, 14'h0132);
        repeat (150) @(posedge clk);
        #1;
        check(dll_locked, 1'b0);
        repeat (60) @(posedge clk);
        #1;
        check(dll_locked, 1'b1);
        mrs(mode_reg_pkg::BANK_MR, 14'h0032);
        mrs(mode_reg_pkg::BANK_EMR1, 14'h0388);
        check({ready, mode_error}, 2'h0);
        mrs(mode_reg_pkg::BANK_EMR1, 14'h0008);
        check({ready, additive_latency}, 4'h9);
        final_report();
    end
endmodule : tb_ddr2_init_and_mode_register

bind ddr2_init_and_mode_register mode_reg_checker chk (.*);
`default_nettype wire
